// File: core/pwm_timer.sv
// dual slope pwm timer with apb registers and asynchronous oscillator clocking
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
module pwm_timer
	import pwm_timer_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// oscillator pin and power states
	input wire logic osc_input_pin_in,
	input wire logic sleep_in,
	input wire logic powerdown_in,
	// outputs
	output logic [1:0] compare_output_out,
	output logic [1:0] compare_oe_out,
	output logic osc_pin_claimed_out,
	output logic wake_out
);

	// decode of a register offset to its holding index
	function automatic logic [2:0] hold_index(input logic [4:0] a);
		unique case (a)
			`OFS_CTRL_A: hold_index = `IDX_CTRL_A;
			`OFS_CTRL_B: hold_index = `IDX_CTRL_B;
			`OFS_COUNT: hold_index = `IDX_COUNT;
			`OFS_CMP_A: hold_index = `IDX_CMP_A;
			`OFS_CMP_B: hold_index = `IDX_CMP_B;
			default: hold_index = `IDX_NONE;
		endcase
	endfunction

	// prescaler mask per clock select code
	function automatic logic [`PRE_W-1:0] pre_mask(input logic [2:0] s);
		unique case (s)
			3'h2: pre_mask = 10'h007;
			3'h3: pre_mask = 10'h01f;
			3'h4: pre_mask = 10'h03f;
			3'h5: pre_mask = 10'h07f;
			3'h6: pre_mask = 10'h0ff;
			3'h7: pre_mask = 10'h3ff;
			default: pre_mask = 10'h000;
		endcase
	endfunction

	ctrl_a_t ctrl_a;
	logic [7:0] ctrl_b;
	logic [7:0] count;
	logic [7:0] count_copy;
	logic [7:0] cmp_a;
	logic [7:0] cmp_b;
	logic async_sel;
	evt_t flags;
	evt_t evt;
	evt_t pipe1;
	evt_t pipe2;
	evt_t set_v;
	dir_t dir;
	logic osc_s1, osc_s2, osc_s3;
	logic osc_edge, src_en, tick;
	logic [`PRE_W-1:0] pre;
	logic [2:0] wgm;
	logic dual;
	logic [7:0] top;
	logic setup, access, wr;
	logic [2:0] widx;
	logic [`HOLD_NUM-1:0] busy;
	logic [`HOLD_NUM-1:0] commit;
	logic [7:0] hold [`HOLD_NUM];
	logic [7:0] cdata [`HOLD_NUM];
	logic [1:0] ecnt [`HOLD_NUM];
	logic [1:0] match;
	logic miss_flag;
	logic wake_pend;
	logic err;
	logic [31:0] next_rdata;

	// oscillator pin synchroniser; s3 only delays s2 for the edge detect
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
		end else begin
			osc_s1 <= osc_input_pin_in;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
		end
	end

	// oscillator is dead in power down, so no edges reach the timer
	assign osc_edge = osc_s2 & ~osc_s3 & ~powerdown_in;
	assign osc_pin_claimed_out = async_sel;
	assign src_en = async_sel ? osc_edge : 1'b1;

	// prescaler; a tick fires when the masked low bits are all ones
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pre <= '0;
		end else if (src_en && ctrl_b[2:0] != `CSEL_STOP) begin
			pre <= pre + 10'h001;
		end
	end
	assign tick = src_en && (ctrl_b[2:0] != `CSEL_STOP) &&
		((pre & pre_mask(ctrl_b[2:0])) == pre_mask(ctrl_b[2:0]));

	// mode decode
	assign wgm = {ctrl_b[`WGM_HI_BIT], ctrl_a.wgm_lo};
	assign dual = (wgm == `WGM_DUAL_FF) || (wgm == `WGM_DUAL_A);
	assign top = (wgm == `WGM_DUAL_A) ? cmp_a : `CNT_MAX;

	// apb decode; the slave never inserts wait states
	assign setup = psel_in & ~penable_in;
	assign access = psel_in & penable_in;
	assign wr = access & pwrite_in & ~err;
	assign widx = hold_index(paddr_in[4:0]);
	assign pready_out = 1'b1;
	assign pslverr_out = access & err;

	// per register holding latch and busy flag
	genvar gi;
	generate
		for (gi = 0; gi < `HOLD_NUM; gi++) begin : g_hold
			logic hit;
			assign hit = wr && (widx == 3'(gi));
			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					hold[gi] <= `RST_BYTE;
					busy[gi] <= 1'b0;
					ecnt[gi] <= 2'h0;
				end else if (hit && async_sel) begin
					hold[gi] <= pwdata_in[7:0];
					busy[gi] <= 1'b1;
					ecnt[gi] <= 2'h0;
				end else if (busy[gi] && osc_edge) begin
					if (ecnt[gi] == `EDGE_LAST) begin
						busy[gi] <= 1'b0;
					end else begin
						ecnt[gi] <= ecnt[gi] + 2'h1;
					end
				end
			end
			// second oscillator edge moves the held byte into place
			assign commit[gi] = (hit && !async_sel) ||
				(busy[gi] && osc_edge && ecnt[gi] == `EDGE_LAST);
			assign cdata[gi] = busy[gi] ? hold[gi] : pwdata_in[7:0];
		end
	endgenerate

	// control and compare destinations
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_a <= '0;
			ctrl_b <= `RST_BYTE;
			cmp_a <= `RST_BYTE;
			cmp_b <= `RST_BYTE;
		end else begin
			if (commit[`IDX_CTRL_A]) ctrl_a <= cdata[`IDX_CTRL_A];
			if (commit[`IDX_CTRL_B]) ctrl_b <= cdata[`IDX_CTRL_B];
			if (commit[`IDX_CMP_A]) cmp_a <= cdata[`IDX_CMP_A];
			if (commit[`IDX_CMP_B]) cmp_b <= cdata[`IDX_CMP_B];
		end
	end

	// clock source select; software follows the safe switching order
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			async_sel <= 1'b0;
		end else if (wr && paddr_in[4:0] == `OFS_ASYNC) begin
			async_sel <= pwdata_in[`ASYNC_SEL_BIT];
		end
	end

	// dual slope counter; top and bottom each last one tick
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count <= `CNT_BOTTOM;
			dir <= DIR_UP;
		end else if (commit[`IDX_COUNT]) begin
			count <= cdata[`IDX_COUNT];
		end else if (tick && dual) begin
			unique case (dir)
				DIR_UP: begin
					if (count >= top) begin
						dir <= DIR_DN;
						count <= count - `CNT_ONE;
					end else begin
						count <= count + `CNT_ONE;
					end
				end
				DIR_DN: begin
					if (count == `CNT_BOTTOM) begin
						dir <= DIR_UP;
						count <= count + `CNT_ONE;
					end else begin
						count <= count - `CNT_ONE;
					end
				end
			endcase
		end
	end

	// a count written above compare a misses the up match this period
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			miss_flag <= 1'b0;
		end else if (commit[`IDX_COUNT]) begin
			miss_flag <= cdata[`IDX_COUNT] > cmp_a;
		end else if (tick && dual && count == `CNT_BOTTOM) begin
			miss_flag <= 1'b0;
		end
	end

	// compare events, blocked while count or compare is in transfer
	assign match[0] = (count == cmp_a) && !busy[`IDX_COUNT] && !busy[`IDX_CMP_A];
	assign match[1] = (count == cmp_b) && !busy[`IDX_COUNT] && !busy[`IDX_CMP_B];
	assign evt[`FLAG_WRAP] = tick && dual && dir == DIR_DN && count == `CNT_ONE;
	assign evt[`FLAG_MA] = tick && dual && match[0];
	assign evt[`FLAG_MB] = tick && dual && match[1];

	// waveform per channel, driven straight from the timer tick
	generate
		for (gi = 0; gi < 2; gi++) begin : g_wave
			logic [7:0] cv;
			logic [1:0] act;
			logic up_lvl;
			logic was_max;
			logic lvl;
			assign cv = gi ? cmp_b : cmp_a;
			assign act = gi ? ctrl_a.action_b : ctrl_a.action_a;
			assign up_lvl = (act == `ACT_INV);
			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					lvl <= 1'b0;
					was_max <= 1'b0;
				end else if (tick && dual) begin
					was_max <= (cv >= top);
					if (cv == `CNT_BOTTOM) begin
						lvl <= up_lvl;
					end else if (cv >= top) begin
						lvl <= ~up_lvl;
					end else if (count == `CNT_BOTTOM && (was_max || (gi == 0 && miss_flag))) begin
						lvl <= up_lvl;
					end else if (match[gi]) begin
						lvl <= (dir == DIR_UP) ? up_lvl : ~up_lvl;
					end
				end
			end
			// pin level is not resynchronised to the bus clock
			assign compare_output_out[gi] = lvl & act[1];
			assign compare_oe_out[gi] = act[1];
		end
	endgenerate

	// async flag sync pipe: two stages plus the flag makes three cycles
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pipe1 <= '0;
			pipe2 <= '0;
		end else begin
			pipe1 <= evt;
			pipe2 <= pipe1;
		end
	end
	assign set_v = async_sel ? pipe2 : evt;

	// flags: write one to clear, a same-cycle set wins
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flags <= '0;
		end else if (wr && paddr_in[4:0] == `OFS_FLAGS) begin
			flags <= (flags & ~pwdata_in[2:0]) | set_v;
		end else begin
			flags <= flags | set_v;
		end
	end

	// wake request starts on the tick after the event while asleep
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wake_pend <= 1'b0;
			wake_out <= 1'b0;
		end else if (!sleep_in) begin
			wake_pend <= 1'b0;
			wake_out <= 1'b0;
		end else begin
			if (|evt) wake_pend <= 1'b1;
			if (tick && wake_pend) wake_out <= 1'b1;
		end
	end

	// bus side copy of count, refreshed only on oscillator edges
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_copy <= `CNT_BOTTOM;
		end else if (osc_edge && !sleep_in) begin
			count_copy <= count;
		end
	end

	// read mux; a stale copy after wake is the price of a safe crossing
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (paddr_in[4:0])
			`OFS_CTRL_A: next_rdata[7:0] = ctrl_a;
			`OFS_CTRL_B: next_rdata[7:0] = ctrl_b;
			`OFS_COUNT: next_rdata[7:0] = async_sel ? count_copy : count;
			`OFS_CMP_A: next_rdata[7:0] = cmp_a;
			`OFS_CMP_B: next_rdata[7:0] = cmp_b;
			`OFS_ASYNC: next_rdata[7:0] = {2'h0, async_sel, busy};
			`OFS_FLAGS: next_rdata[2:0] = flags;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// read data and error are captured in the setup cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prdata_out <= 32'h0000_0000;
			err <= 1'b0;
		end else if (setup) begin
			prdata_out <= next_rdata;
			err <= (paddr_in[31:5] != 27'h0) || (paddr_in[1:0] != 2'h0) ||
				(paddr_in[4:0] > `OFS_FLAGS);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_async_wr_count;
		wr && async_sel && widx == `IDX_COUNT;
	endsequence

	a_busy_on_write: assert property (s_async_wr_count |=> busy[`IDX_COUNT])
		else $error("busy not raised by async count write");
	a_busy_clears: assert property (busy[`IDX_CMP_A] && osc_edge &&
		ecnt[`IDX_CMP_A] == `EDGE_LAST && !wr |=> !busy[`IDX_CMP_A])
		else $error("busy did not clear on second edge");
	a_commit_value: assert property (commit[`IDX_CMP_B] && busy[`IDX_CMP_B]
		|=> cmp_b == $past(hold[`IDX_CMP_B]))
		else $error("compare b not loaded from its holding register");
	a_top_turn: assert property (tick && dual && dir == DIR_UP && count >= top &&
		!commit[`IDX_COUNT] |=> dir == DIR_DN)
		else $error("no reversal after top");
	a_wrap_sync: assert property (!async_sel && evt[`FLAG_WRAP] |=> flags[`FLAG_WRAP])
		else $error("wrap flag not set at bottom");
	a_flag_delay: assert property (async_sel && evt[`FLAG_MA] ##1 async_sel[*2]
		|=> flags[`FLAG_MA])
		else $error("async flag sync took wrong time");
	a_match_block: assert property (busy[`IDX_CMP_A] || busy[`IDX_COUNT]
		|-> !evt[`FLAG_MA])
		else $error("compare match during transfer");
	a_tick_source: assert property (tick |-> src_en && ctrl_b[2:0] != `CSEL_STOP)
		else $error("tick without enabled source");
	a_copy_frozen: assert property (sleep_in |=> $stable(count_copy))
		else $error("count copy changed while asleep");
	a_up_clear: assert property (tick && dual && dir == DIR_UP && match[0] &&
		ctrl_a.action_a == `ACT_NONINV && cmp_a != `CNT_BOTTOM && cmp_a < top &&
		count != `CNT_BOTTOM |=> !g_wave[0].lvl)
		else $error("up match did not clear output");
	a_pd_no_edge: assert property (powerdown_in |-> !osc_edge)
		else $error("osc edge in power down");

endmodule

// File: core/pwm_timer_params.svh
// constants for the dual slope pwm timer with asynchronous clocking
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH
// register byte offsets
`define OFS_CTRL_A 5'h00
`define OFS_CTRL_B 5'h04
`define OFS_COUNT 5'h08
`define OFS_CMP_A 5'h0c
`define OFS_CMP_B 5'h10
`define OFS_ASYNC 5'h14
`define OFS_FLAGS 5'h18
// holding register indices
`define HOLD_NUM 5
`define IDX_CTRL_A 3'h0
`define IDX_CTRL_B 3'h1
`define IDX_COUNT 3'h2
`define IDX_CMP_A 3'h3
`define IDX_CMP_B 3'h4
`define IDX_NONE 3'h7
// field positions
`define ASYNC_SEL_BIT 5
`define WGM_HI_BIT 3
`define FLAG_WRAP 0
`define FLAG_MA 1
`define FLAG_MB 2
// mode codes and values
`define WGM_DUAL_FF 3'h1
`define WGM_DUAL_A 3'h5
`define ACT_NONINV 2'h2
`define ACT_INV 2'h3
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define CNT_ONE 8'h01
`define EDGE_LAST 2'h1
`define CSEL_STOP 3'h0
`define PRE_W 10
`define RST_BYTE 8'h00
`endif

// File: core/pwm_timer_pkg.sv
// types shared by the dual slope pwm timer
package pwm_timer_pkg;
	// counting direction, one-hot
	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DN = 2'b10
	} dir_t;
	// control register a layout
	typedef struct packed {
		logic [1:0] action_a;
		logic [1:0] action_b;
		logic [1:0] spare;
		logic [1:0] wgm_lo;
	} ctrl_a_t;
	// timer events: bit0 wrap, bit1 match a, bit2 match b
	typedef logic [2:0] evt_t;
endpackage

// File: dv/osc_model.sv
// behavioural model of the external low-frequency crystal on the oscillator pin
`timescale 1ns/1ps
module osc_model #(
	parameter int HALF_NS = 50
) (
	// enable from the bench and the pin itself
	input wire logic run_in,
	output logic osc_out
);
	// swings only while enabled; parked low otherwise so no stale edge appears
	// one process owns the pin, and it parks low at time zero before any swing
	always begin
		if (run_in) begin
			osc_out = ~osc_out;
		end else begin
			osc_out = 1'b0;
		end
		#(HALF_NS);
	end
endmodule

// File: dv/tb_top.sv
// self-checking bench for the dual slope pwm timer
`timescale 1ns/1ps
`include "pwm_timer_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_top
	import pwm_timer_pkg::*;
;
	logic clk_in = 1'b0, rstn_in, psel, penable, pwrite, osc_run, osc_pin;
	logic [31:0] paddr, pwdata, prdata;
	logic pready, pslverr, claimed, wake;
	logic sleep, pdown;
	logic [1:0] cout, coe;
	int n_errors = 0;
	int tests_run = 0;
	int n_osc = 0;
	pwm_timer DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .osc_input_pin_in(osc_pin),
		.sleep_in(sleep), .powerdown_in(pdown), .compare_output_out(cout),
		.compare_oe_out(coe), .osc_pin_claimed_out(claimed), .wake_out(wake));
	osc_model xtal (.run_in(osc_run), .osc_out(osc_pin));
	always #2.5 clk_in = ~clk_in;
	always @(posedge osc_pin) n_osc++;
	task stop_test;
		$display("errors %0d, comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one apb transfer; the request is held until pready is seen high
	task apb(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int i;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {27'h0, a};
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_in);
			i++;
		end while (pready !== 1'b1 && i < 64);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 64) begin
			n_errors++;
			stop_test();
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h000000, d}, r, e);
	endtask
	task rdc(input logic [4:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		`CHK(e, 1'b0)
		`CHK(r, x)
	endtask
	// bounded wait until a channel shows the given level, counting cycles
	task wait_lvl(input int ch, input logic lvl, output int n);
		n = 0;
		while (cout[ch] !== lvl && n < 40000) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 40000) begin
			n_errors++;
			stop_test();
		end
	endtask
	// first interval is discarded: the prescaler phase is not reset on a change
	task measure(input int ch, output int h, output int p);
		int n;
		wait_lvl(ch, 1'b0, n);
		wait_lvl(ch, 1'b1, n);
		wait_lvl(ch, 1'b0, h);
		wait_lvl(ch, 1'b1, n);
		p = h + n;
	endtask
	task steady(input int ch, input logic lvl);
		logic ok;
		ok = 1'b1;
		repeat (520) @(posedge clk_in);
		repeat (520) begin
			@(posedge clk_in);
			if (cout[ch] !== lvl) ok = 1'b0;
		end
		`CHK(ok, 1'b1)
	endtask
	task t_reset;
		logic [31:0] r;
		logic e;
		rdc(`OFS_CTRL_A, 32'h0);
		rdc(`OFS_CTRL_B, 32'h0);
		rdc(`OFS_ASYNC, 32'h0);
		apb(1'b0, 5'h1c, 32'h0, r, e);
		`CHK(e, 1'b1)
		`CHK(r, 32'h0)
	endtask
	task t_dual;
		int h, p;
		wr(`OFS_CMP_A, 8'h40);
		wr(`OFS_CTRL_A, 8'h81);
		wr(`OFS_CTRL_B, 8'h01);
		measure(0, h, p);
		`CHK(p, 510)
		`CHK(h >= 126 && h <= 130, 1'b1)
		`CHK(coe, 2'b01)
		wr(`OFS_CTRL_A, 8'hc1);
		measure(0, h, p);
		`CHK(h >= 380 && h <= 384, 1'b1)
	endtask
	task t_extreme;
		wr(`OFS_CTRL_A, 8'h81);
		wr(`OFS_CMP_A, 8'h00);
		steady(0, 1'b0);
		wr(`OFS_CMP_A, 8'hff);
		steady(0, 1'b1);
		wr(`OFS_CTRL_A, 8'hc1);
		steady(0, 1'b0);
	endtask
	task t_top_a;
		int h, p;
		wr(`OFS_CMP_A, 8'h20);
		wr(`OFS_CMP_B, 8'h10);
		wr(`OFS_CTRL_A, 8'h21);
		wr(`OFS_CTRL_B, 8'h09);
		measure(1, h, p);
		`CHK(p, 64)
		`CHK(h >= 30 && h <= 34, 1'b1)
		`CHK(coe, 2'b10)
	endtask
	task t_prescale;
		int h, p, div[3];
		logic [31:0] r1, r2;
		logic e;
		div = '{1, 8, 32};
		wr(`OFS_CMP_A, 8'h40);
		wr(`OFS_CTRL_A, 8'h81);
		for (int s = 0; s < 3; s++) begin
			wr(`OFS_CTRL_B, 8'(s + 1));
			measure(0, h, p);
			`CHK(p, 510 * div[s])
		end
		wr(`OFS_CTRL_B, 8'h00);
		apb(1'b0, `OFS_COUNT, 32'h0, r1, e);
		repeat (20) @(posedge clk_in);
		apb(1'b0, `OFS_COUNT, 32'h0, r2, e);
		`CHK(r1, r2)
	endtask
	task t_wrap;
		logic [31:0] r;
		logic e;
		apb(1'b0, `OFS_FLAGS, 32'h0, r, e);
		`CHK(r[`FLAG_WRAP], 1'b1)
		wr(`OFS_FLAGS, 8'h07);
		rdc(`OFS_FLAGS, 32'h0);
	endtask
	task wait_osc(input int k);
		int i;
		i = 0;
		while (n_osc < k && i < 2000) begin
			@(posedge clk_in);
			i++;
		end
		if (i >= 2000) begin
			n_errors++;
			stop_test();
		end
		repeat (8) @(posedge clk_in);
	endtask
	// clock source switch kept in the safe order, oscillator held still at first
	task t_async;
		wr(`OFS_ASYNC, 8'h20);
		// the select lands at the access edge, so look one edge later
		@(posedge clk_in);
		`CHK(claimed, 1'b1)
		wr(`OFS_CMP_A, 8'h33);
		wr(`OFS_CMP_B, 8'h44);
		wr(`OFS_COUNT, 8'h5a);
		rdc(`OFS_ASYNC, 32'h3c);
		repeat (40) @(posedge clk_in);
		rdc(`OFS_ASYNC, 32'h3c);
		osc_run <= 1'b1;
		wait_osc(1);
		rdc(`OFS_ASYNC, 32'h3c);
		wait_osc(2);
		rdc(`OFS_ASYNC, 32'h20);
		rdc(`OFS_CMP_A, 32'h33);
		rdc(`OFS_CMP_B, 32'h44);
		// the copy lags the count by one edge; the wait for two more edges lets it catch up
		wr(`OFS_CMP_B, 8'h44);
		wait_osc(n_osc + 2);
		rdc(`OFS_COUNT, 32'h5a);
		wr(`OFS_FLAGS, 8'h07);
	endtask
	// timer runs on oscillator ticks while asleep, then power down stalls transfers
	task t_sleep;
		logic [31:0] r1, r2;
		logic e;
		int n;
		wr(`OFS_CTRL_B, 8'h09);
		wait_osc(n_osc + 2);
		rdc(`OFS_CTRL_B, 32'h09);
		sleep <= 1'b1;
		repeat (2) @(posedge clk_in);
		`CHK(wake, 1'b0)
		apb(1'b0, `OFS_COUNT, 32'h0, r1, e);
		wait_osc(n_osc + 2);
		apb(1'b0, `OFS_COUNT, 32'h0, r2, e);
		`CHK(r1, r2)
		n = 0;
		while (wake !== 1'b1 && n < 4000) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 4000) begin
			n_errors++;
			stop_test();
		end
		`CHK(wake, 1'b1)
		sleep <= 1'b0;
		pdown <= 1'b1;
		wr(`OFS_CMP_B, 8'h55);
		wait_osc(n_osc + 3);
		rdc(`OFS_ASYNC, 32'h30);
		pdown <= 1'b0;
		wait_osc(n_osc + 2);
		rdc(`OFS_ASYNC, 32'h20);
		rdc(`OFS_CMP_B, 32'h55);
	endtask
	initial begin
		rstn_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		osc_run = 1'b0;
		sleep = 1'b0;
		pdown = 1'b0;
		repeat (20) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_dual();
		t_extreme();
		t_top_a();
		t_prescale();
		t_wrap();
		t_async();
		t_sleep();
		stop_test();
	end
endmodule
